// ---- design/mbg_bus_glue.v ----
`timescale 1ns/10ps
`include "mbg_consts.vh"
// How it works
// - cpu holds the bus whenever no alternate master requests.
// - hdlc or lan request raises the second-stage request.
// - first stage makes cpu release, then grants stage two, passed on.
// - hdlc wins over lan when both request together.
// - losing lan request waits until hdlc done and bus returned to cpu.
// - lan request/grant turned into host request/grant signalling.
// - hdlc address strobe drives host transfer start while it owns bus.
// - cycle ack asserted two bus clocks after address strobe seen low.
// - transfer start released on the same clock that cycle ack goes low.
// - transfer start tristated when hdlc is not bus owner.
// - cpu write to one fixed address yields the action request pulse.
// - low address bits and size generated for lan 8/16/32-bit cycles.
// - lan signals synchronised into the bus clock domain.
module mbg_bus_glue (
	// clock and reset
	input wire clk_sys_i,
	input wire rst_n_i,
	// cpu side arbitration
	output wire cpu_bus_req_o,
	input wire cpu_bus_granted_i,
	output wire cpu_bus_grant_o,
	// hdlc controller arbitration
	input wire hdlc_hold_req_i,
	output wire hdlc_hold_ack_o,
	// lan controller arbitration, active high hold style
	input wire lan_hold_i,
	output wire lan_hlda_o,
	// hdlc bus cycle
	input wire address_strobe_n_i,
	input wire write_data_valid_n_i,
	output wire cycle_ack_n_o,
	// host bus transfer start, three-state
	output wire transfer_start_n_o,
	output wire transfer_start_oe_o,
	input wire xfer_done_n_i,
	// lan bus cycle
	input wire [3:0] lan_be_n_i,
	output wire [1:0] lan_addr_lo_o,
	output wire [1:0] lan_siz_o,
	// cpu write decode
	input wire [31:2] cpu_addr_i,
	input wire cpu_write_i,
	input wire cpu_strobe_i,
	output wire action_req_o
);
	////////////////////////////////////////////////////////////////
	wire [5:0] lan_sync;
	wire hdlc_req_s;
	wire lan_req_s;
	wire [3:0] be_s;
	mbg_sync2 #(.W(6)) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.d_i({hdlc_hold_req_i, lan_hold_i, lan_be_n_i}),
		.q_o(lan_sync)
	);
	assign hdlc_req_s = lan_sync[5];
	assign lan_req_s = lan_sync[4];
	assign be_s = lan_sync[3:0];
	////////////////////////////////////////////////////////////////
	// arbiter
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg cpu_req_ff;
	reg cpu_grant_ff;
	reg hdlc_ack_ff;
	reg lan_ack_ff;
	wire alt_req = hdlc_req_s | lan_req_s;
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			`MBG_ST_CPU: begin
				if (alt_req)
					nxt_state = `MBG_ST_RLS;
			end
			`MBG_ST_RLS: begin
				if (!alt_req)
					nxt_state = `MBG_ST_CPU;
				else if (!cpu_bus_granted_i) begin
					if (hdlc_req_s)
						nxt_state = `MBG_ST_HDLC;
					else
						nxt_state = `MBG_ST_LAN;
				end
			end
			`MBG_ST_HDLC: begin
				if (!hdlc_req_s)
					nxt_state = `MBG_ST_CPU;
			end
			`MBG_ST_LAN: begin
				if (!lan_req_s)
					nxt_state = `MBG_ST_CPU;
			end
			default: nxt_state = `MBG_ST_CPU;
		endcase
	end
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state_ff <= `MBG_ST_CPU;
			cpu_req_ff <= 1'b0;
			cpu_grant_ff <= 1'b1;
			hdlc_ack_ff <= 1'b0;
			lan_ack_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cpu_req_ff <= (nxt_state != `MBG_ST_CPU);
			cpu_grant_ff <= (nxt_state == `MBG_ST_CPU);
			hdlc_ack_ff <= (nxt_state == `MBG_ST_HDLC);
			lan_ack_ff <= (nxt_state == `MBG_ST_LAN);
		end
	end
	////////////////////////////////////////////////////////////////
	// hdlc cycle adaptation
	reg [1:0] as_sync_ff;
	reg [1:0] ack_cnt_ff;
	reg ack_n_ff;
	reg ts_n_ff;
	reg ts_oe_ff;
	wire as_low = ~as_sync_ff[1];
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			as_sync_ff <= 2'b11;
			ack_cnt_ff <= 2'd0;
			ack_n_ff <= 1'b1;
			ts_n_ff <= 1'b1;
			ts_oe_ff <= 1'b0;
		end else begin
			as_sync_ff <= {as_sync_ff[0], address_strobe_n_i};
			// enable drops with the grant, never overlaps the cpu
			ts_oe_ff <= (nxt_state == `MBG_ST_HDLC);
			if (!hdlc_ack_ff || !as_low) begin
				ack_cnt_ff <= 2'd0;
				ack_n_ff <= 1'b1;
				ts_n_ff <= 1'b1;
			end else if (ack_cnt_ff == `MBG_ACK_DELAY - 2'd1) begin
				ack_n_ff <= 1'b0;
				ts_n_ff <= 1'b1;
			end else begin
				ack_cnt_ff <= ack_cnt_ff + 2'd1;
				if (ack_cnt_ff == 2'd0)
					ts_n_ff <= 1'b0;
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// lan address and size
	reg [1:0] addr_lo_ff;
	reg [1:0] siz_ff;
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			addr_lo_ff <= 2'd0;
			siz_ff <= `MBG_SIZ_LONG;
		end else begin
			case (be_s)
				`MBG_BE_LONG: begin
					addr_lo_ff <= 2'd0;
					siz_ff <= `MBG_SIZ_LONG;
				end
				`MBG_BE_WORD_LO: begin
					addr_lo_ff <= 2'd0;
					siz_ff <= `MBG_SIZ_WORD;
				end
				`MBG_BE_WORD_HI: begin
					addr_lo_ff <= 2'd2;
					siz_ff <= `MBG_SIZ_WORD;
				end
				4'he: begin
					addr_lo_ff <= 2'd0;
					siz_ff <= `MBG_SIZ_BYTE;
				end
				4'hd: begin
					addr_lo_ff <= 2'd1;
					siz_ff <= `MBG_SIZ_BYTE;
				end
				4'hb: begin
					addr_lo_ff <= 2'd2;
					siz_ff <= `MBG_SIZ_BYTE;
				end
				4'h7: begin
					addr_lo_ff <= 2'd3;
					siz_ff <= `MBG_SIZ_BYTE;
				end
				default: begin
					addr_lo_ff <= 2'd0;
					siz_ff <= `MBG_SIZ_LONG;
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	// action request decode, one pulse per write
	reg ar_ff;
	reg ar_seen_ff;
	wire ar_hit = cpu_strobe_i & cpu_write_i & (cpu_addr_i == `MBG_AR_ADDR);
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ar_ff <= 1'b0;
			ar_seen_ff <= 1'b0;
		end else begin
			ar_seen_ff <= ar_hit;
			ar_ff <= ar_hit & ~ar_seen_ff;
		end
	end
	////////////////////////////////////////////////////////////////
	assign cpu_bus_req_o = cpu_req_ff;
	assign cpu_bus_grant_o = cpu_grant_ff;
	assign hdlc_hold_ack_o = hdlc_ack_ff;
	assign lan_hlda_o = lan_ack_ff;
	assign cycle_ack_n_o = ack_n_ff;
	assign transfer_start_n_o = ts_n_ff;
	assign transfer_start_oe_o = ts_oe_ff;
	assign lan_addr_lo_o = addr_lo_ff;
	assign lan_siz_o = siz_ff;
	assign action_req_o = ar_ff;
endmodule

// ---- design/mbg_consts.vh ----
`ifndef MBG_CONSTS_VH
`define MBG_CONSTS_VH
// cycle acknowledge delay after address strobe seen low, in bus clocks
`define MBG_ACK_DELAY 2'd2
// action request decode address, word address bits [31:2]
`define MBG_AR_ADDR 30'h3fff_fff0
// transfer size codes on the host bus
`define MBG_SIZ_LONG 2'b00
`define MBG_SIZ_BYTE 2'b01
`define MBG_SIZ_WORD 2'b10
// lan byte enable patterns, active low
`define MBG_BE_LONG 4'h0
`define MBG_BE_WORD_LO 4'hc
`define MBG_BE_WORD_HI 4'h3
// arbiter states
`define MBG_ST_CPU 2'd0
`define MBG_ST_RLS 2'd1
`define MBG_ST_HDLC 2'd2
`define MBG_ST_LAN 2'd3
`endif

// ---- design/mbg_sync2.v ----
`timescale 1ns/10ps
module mbg_sync2 #(
	parameter W = 1
) (
	// clock and reset
	input wire clk_sys_i,
	input wire rst_n_i,
	// data
	input wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			meta_ff <= {W{1'b0}};
			sync_ff <= {W{1'b0}};
		end else begin
			meta_ff <= d_i;
			sync_ff <= meta_ff;
		end
	end
	assign q_o = sync_ff;
endmodule

// ---- dv/mbg_bus_glue_asserts.sv ----
`timescale 1ns/10ps
`include "mbg_consts.vh"
module mbg_chk (
	input wire clk_sys_i, rst_n_i, cpu_bus_req_o, cpu_bus_granted_i, cpu_bus_grant_o,
	input wire hdlc_hold_ack_o, lan_hlda_o, cycle_ack_n_o, transfer_start_n_o,
	input wire transfer_start_oe_o, cpu_write_i, cpu_strobe_i, action_req_o,
	input wire [1:0] lan_siz_o, lan_addr_lo_o,
	input wire [31:2] cpu_addr_i
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	a_one_owner: assert property (
		$onehot0({cpu_bus_grant_o, hdlc_hold_ack_o, lan_hlda_o})) else $error("two owners");
	a_grant_wait: assert property (
		$rose(hdlc_hold_ack_o) || $rose(lan_hlda_o) |-> !$past(cpu_bus_granted_i))
		else $error("grant before cpu let go");
	a_lan_via_stage: assert property (
		$rose(lan_hlda_o) |-> $past(cpu_bus_req_o)) else $error("lan grant not via stage two");
	a_back_to_cpu: assert property (
		$fell(hdlc_hold_ack_o) |-> cpu_bus_grant_o) else $error("bus not back to cpu");
	a_ack_two_clk: assert property (
		$fell(transfer_start_n_o) |=> $fell(cycle_ack_n_o) && transfer_start_n_o)
		else $error("ack not two clocks after strobe");
	a_ts_released: assert property (
		!cycle_ack_n_o |-> transfer_start_n_o) else $error("start held during ack");
	a_ts_float: assert property (
		transfer_start_oe_o == hdlc_hold_ack_o)
		else $error("start driven without ownership");
	a_action_pulse: assert property (
		action_req_o |-> $past(cpu_strobe_i && cpu_write_i && cpu_addr_i == `MBG_AR_ADDR)
		##1 !action_req_o) else $error("bad action pulse");
	a_size_legal: assert property (
		lan_siz_o != 2'b11) else $error("illegal size code");
	a_size_align: assert property (
		lan_siz_o != `MBG_SIZ_BYTE |-> !lan_addr_lo_o[0]) else $error("misaligned size");
endmodule

// ---- dv/mbg_bus_glue_tb.sv ----
`timescale 1ns/10ps
`include "mbg_consts.vh"
module mbg_bus_glue_tb;
	logic clk_sys_i = 0, rst_n_i = 0, hq = 0, lq = 0, as_n = 1, wr = 0, st = 0, gr;
	logic [3:0] be = 4'hf, dly = 0;
	logic [31:2] ad = 0;
	wire br, bg, ha, la, ack_n, ts_n, oe, ar;
	wire [1:0] lo, sz;
	int err_total = 0, cmp_count = 0, n;
	logic [7:0] tb_t[8] = '{8'h00, 8'hc8, 8'h3a, 8'he4, 8'hd5, 8'hb6, 8'h77, 8'h50};
	always #12.5 clk_sys_i = ~clk_sys_i;
	mbg_bus_glue DUT(.clk_sys_i, .rst_n_i, .cpu_bus_req_o(br), .cpu_bus_granted_i(gr),
		.cpu_bus_grant_o(bg), .hdlc_hold_req_i(hq), .hdlc_hold_ack_o(ha), .lan_hold_i(lq),
		.lan_hlda_o(la), .address_strobe_n_i(as_n), .write_data_valid_n_i(as_n),
		.cycle_ack_n_o(ack_n), .transfer_start_n_o(ts_n), .transfer_start_oe_o(oe),
		.xfer_done_n_i(ts_n), .lan_be_n_i(be), .lan_addr_lo_o(lo), .lan_siz_o(sz),
		.cpu_addr_i(ad), .cpu_write_i(wr), .cpu_strobe_i(st), .action_req_o(ar));
	mbg_cpu_model CPU(.clk_sys_i, .cpu_bus_req_o(br), .dly, .cpu_bus_granted_i(gr));
	////////////////////////////////////////////////////////////////////////////
	task cyc(int k);
		repeat (k) @(posedge clk_sys_i);
	endtask
	task chk(logic [7:0] s, e, string nm);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("FAIL %s exp %h got %h", nm, e, s);
		end
	endtask
	task tally_and_finish;
		if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task wt(int i, logic v);
		logic [3:0] w;
		n = 0;
		do begin
			cyc(1);
			#1;
			n++;
			w = {ts_n, bg, la, ha};
		end while (w[i] !== v && n < 60);
		chk(w[i], v, "wait");
	endtask
	////////////////////////////////////////////////////////////////////////////
	task t_arb(logic [3:0] d);
		cyc(1);
		dly <= d;
		hq <= 1;
		lq <= 1;
		wt(0, 1);
		chk({bg, la}, 0, "hdlc own");
		cyc(1);
		as_n <= 0;
		wt(3, 0);
		chk(oe, 1, "start drive");
		cyc(1);
		#1;
		chk({ack_n, ts_n}, 1, "ack");
		cyc(1);
		as_n <= 1;
		cyc(3);
		#1;
		chk(ack_n, 1, "ack end");
		cyc(1);
		hq <= 0;
		wt(2, 1);
		chk({la, oe}, 0, "back cpu");
		wt(1, 1);
		chk(bg, 0, "lan own");
		cyc(1);
		lq <= 0;
		wt(2, 1);
		chk(la, 0, "lan done");
	endtask
	task t_siz;
		foreach (tb_t[i]) begin
			cyc(1);
			be <= tb_t[i][7:4];
			cyc(3);
			#1;
			chk({sz, lo}, tb_t[i][3:0], "size");
		end
	endtask
	task t_ar;
		for (int i = 0; i < 3; i++) begin
			cyc(1);
			st <= 1;
			wr <= i != 1;
			ad <= `MBG_AR_ADDR + (i == 2);
			cyc(1);
			st <= 0;
			n = 0;
			repeat (3) begin
				#1 n += ar;
				cyc(1);
			end
			chk(n, i == 0, "action");
			if (i == 0) begin
				hq <= 1;
				wt(0, 1);
				cyc(1);
				hq <= 0;
				wt(2, 1);
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(19);
		#1;
		chk({bg, ha, la, br, ack_n, ts_n, oe, ar}, 8'h8c, "reset");
		cyc(1);
		rst_n_i <= 1;
		t_arb(0);
		t_arb(3);
		t_siz;
		t_ar;
		tally_and_finish;
	end
	initial begin
		#100000;
		err_total++;
		tally_and_finish;
	end
endmodule
bind mbg_bus_glue mbg_chk CHK(.clk_sys_i, .rst_n_i, .cpu_bus_req_o, .cpu_bus_granted_i,
	.cpu_bus_grant_o, .hdlc_hold_ack_o, .lan_hlda_o, .cycle_ack_n_o, .transfer_start_n_o,
	.transfer_start_oe_o, .cpu_write_i, .cpu_strobe_i, .action_req_o, .lan_siz_o,
	.lan_addr_lo_o, .cpu_addr_i);

// ---- dv/mbg_cpu_model.sv ----
`timescale 1ns/10ps
module mbg_cpu_model (
	input wire logic clk_sys_i, cpu_bus_req_o,
	input wire logic [3:0] dly,
	output logic cpu_bus_granted_i
);
	int n = 0;
	initial cpu_bus_granted_i = 1;
	// cpu lets go of the bus dly cycles after being asked
	always @(posedge clk_sys_i) begin
		n <= cpu_bus_req_o ? n + 1 : 0;
		cpu_bus_granted_i <= !(cpu_bus_req_o && n >= dly);
	end
endmodule
